// ==== design/cpd_column_packet_decoder.v ====
// Column packet decoder with AXI4-Lite register slave
//
// Functional notes
// - Primary packets are taken only in attention state; ignored in standby.
// - Every taken primary packet retires the write buffer, any device field.
// - Matching opcode x000 only retires; x010 and x110 also only retire.
// - Write: retire first, then load addressed column into write buffer.
// - Read: read addressed column of addressed bank.
// - Column precharge: retire, then precharge addressed bank.
// - Write with autoprecharge: precharge bank after the new data retires.
// - Read with autoprecharge: read, then precharge bank afterwards.
// - Top primary opcode bit set moves the device to standby.
// - Combined primary opcode bits perform every requested action.
// - Select bit 1: secondary packet holds two 8-bit bytemasks for writes.
// - Select bit 0: extended command; mismatch or opcode 00000 is no-op.
// - Extended opcode 1xxx0 precharges the extended bank.
// - Extended opcode x10x0 drives the calibration level.
// - Extended opcode x11x0 drives and samples the calibration level.
// - Extended opcode xxx10 moves the device to standby.
// - Combined extended opcode bits perform every requested action.
// - Bytemask bit 1 writes its byte, 0 suppresses; bit 0 is earliest.
// - Framing bit recognises the primary packet and locates the secondary.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_defines.vh"

module cpd_column_packet_decoder #(
    parameter ADDR_W = 4,
    parameter CNT_W = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire col_frame_pin,
    input wire [20:0] primary_column_packet,
    input wire [16:0] secondary_packet,
    output reg attention_state_r,
    output reg retire_r,
    output reg write_r,
    output reg read_r,
    output reg col_prech_r,
    output reg auto_prech_r,
    output reg [4:0] bank_r,
    output reg [6:0] column_r,
    output reg [4:0] auto_bank_r,
    output reg ext_prech_r,
    output reg [4:0] ext_bank_r,
    output reg cal_drive_r,
    output reg cal_sample_r,
    output reg [7:0] lane_a_bytemask_r,
    output reg [7:0] lane_b_bytemask_r
);

    // Pin synchroniser, three stages
    reg [`CPD_PIN_W-1:0] pin_s1_r;
    reg [`CPD_PIN_W-1:0] pin_s2_r;
    reg [`CPD_PIN_W-1:0] pin_s3_r;
    reg frame_seen_r;
    wire pins_stable;
    wire new_frame;
    wire [20:0] prim;
    wire [16:0] sec;
    wire [4:0] pdev;
    wire [2:0] op_low;
    wire [4:0] xop;
    wire prim_match;
    wire ext_match;
    wire take;
    wire xop_act;

    reg [4:0] own_device_identifier_r;
    reg wra_pend_r;
    reg [4:0] wra_bank_r;
    reg rda_pend_r;
    reg [4:0] rda_bank_r;
    reg [CNT_W-1:0] taken_cnt_r;
    reg [CNT_W-1:0] refused_cnt_r;

    reg aw_held_r;
    reg w_held_r;
    reg [ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    wire wr_go;
    wire rd_go;
    reg wr_hit;
    reg [31:0] rd_data;
    reg rd_hit;
    reg set_attention_state;

    assign pins_stable = (pin_s2_r == pin_s3_r);
    // Rising edge of the framing bit marks a packet pair
    assign new_frame = pins_stable && pin_s3_r[`CPD_PIN_FRAME] &&
        !frame_seen_r;
    assign prim = pin_s3_r[`CPD_PRIM_HI:`CPD_PRIM_LO];
    assign sec = pin_s3_r[`CPD_SEC_HI:`CPD_SEC_LO];
    assign pdev = prim[`CPD_PDEV_HI:`CPD_PDEV_LO];
    assign op_low = prim[`CPD_POP_LOW_HI:`CPD_POP_LOW_LO];
    assign xop = sec[`CPD_XOP_HI:`CPD_XOP_LO];
    assign take = new_frame && attention_state_r;
    assign prim_match = (pdev == own_device_identifier_r);
    assign ext_match = !sec[`CPD_SEL_BIT] &&
        (sec[`CPD_XDEV_HI:`CPD_XDEV_LO] == own_device_identifier_r);
    // Reserved and null extended opcodes do nothing
    assign xop_act = ext_match && (xop != `CPD_XOP_NOP) &&
        !xop[`CPD_XOP_RSV];

    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always @*
    begin
        wr_hit = 1'b0;
        set_attention_state = 1'b0;
        case (awaddr_r)
            `CPD_OFS_DEVID: wr_hit = 1'b1;
            `CPD_OFS_POWER:
            begin
                wr_hit = 1'b1;
                set_attention_state = wr_go && wstrb_r[0] && wdata_r[`CPD_PWR_ATTENTION_STATE];
            end
            default: wr_hit = 1'b0;
        endcase
    end

    always @*
    begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CPD_OFS_DEVID: rd_data[4:0] = own_device_identifier_r;
            `CPD_OFS_POWER: rd_data[`CPD_PWR_ATTENTION_STATE] = attention_state_r;
            `CPD_OFS_MASK: rd_data[15:0] = {lane_b_bytemask_r,
                lane_a_bytemask_r};
            `CPD_OFS_COUNT: rd_data = {refused_cnt_r, taken_cnt_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_r <= {`CPD_PIN_W{1'b0}};
            pin_s2_r <= {`CPD_PIN_W{1'b0}};
            pin_s3_r <= {`CPD_PIN_W{1'b0}};
            frame_seen_r <= 1'b0;
        end
        else if (ce)
        begin
            pin_s1_r <= {col_frame_pin, primary_column_packet,
                secondary_packet};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pins_stable)
                frame_seen_r <= pin_s3_r[`CPD_PIN_FRAME];
        end
    end

    // Command decode
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            attention_state_r <= 1'b1;
            retire_r <= 1'b0;
            write_r <= 1'b0;
            read_r <= 1'b0;
            col_prech_r <= 1'b0;
            auto_prech_r <= 1'b0;
            bank_r <= 5'h00;
            column_r <= 7'h00;
            auto_bank_r <= 5'h00;
            ext_prech_r <= 1'b0;
            ext_bank_r <= 5'h00;
            cal_drive_r <= 1'b0;
            cal_sample_r <= 1'b0;
            lane_a_bytemask_r <= `CPD_MASK_RST;
            lane_b_bytemask_r <= `CPD_MASK_RST;
            wra_pend_r <= 1'b0;
            wra_bank_r <= 5'h00;
            rda_pend_r <= 1'b0;
            rda_bank_r <= 5'h00;
            taken_cnt_r <= {CNT_W{1'b0}};
            refused_cnt_r <= {CNT_W{1'b0}};
        end
        else if (ce)
        begin
            retire_r <= take;
            write_r <= 1'b0;
            read_r <= 1'b0;
            col_prech_r <= 1'b0;
            auto_prech_r <= 1'b0;
            ext_prech_r <= 1'b0;
            cal_drive_r <= 1'b0;
            cal_sample_r <= 1'b0;
            rda_pend_r <= 1'b0;
            if (new_frame && !attention_state_r)
                refused_cnt_r <= refused_cnt_r + 1'b1;
            // Deferred read precharge follows the read by one cycle
            if (rda_pend_r)
            begin
                auto_prech_r <= 1'b1;
                auto_bank_r <= rda_bank_r;
            end
            if (take)
            begin
                taken_cnt_r <= taken_cnt_r + 1'b1;
                bank_r <= prim[`CPD_PBANK_HI:`CPD_PBANK_LO];
                column_r <= prim[`CPD_PCOL_HI:`CPD_PCOL_LO];
                // Retiring the buffer releases a pending write precharge
                if (wra_pend_r)
                begin
                    auto_prech_r <= 1'b1;
                    auto_bank_r <= wra_bank_r;
                    wra_pend_r <= 1'b0;
                end
                if (prim_match)
                begin
                    case (op_low)
                        `CPD_OP_WR: write_r <= 1'b1;
                        `CPD_OP_RD: read_r <= 1'b1;
                        `CPD_OP_COLUMN_PRECHARGE_CMD: col_prech_r <= 1'b1;
                        `CPD_OP_WRA:
                        begin
                            write_r <= 1'b1;
                            wra_pend_r <= 1'b1;
                            wra_bank_r <= prim[`CPD_PBANK_HI:`CPD_PBANK_LO];
                        end
                        `CPD_OP_RDA:
                        begin
                            read_r <= 1'b1;
                            rda_pend_r <= 1'b1;
                            rda_bank_r <= prim[`CPD_PBANK_HI:`CPD_PBANK_LO];
                        end
                        default: write_r <= 1'b0;
                    endcase
                end
                if (sec[`CPD_SEL_BIT])
                begin
                    lane_a_bytemask_r <= sec[`CPD_MA_HI:`CPD_MA_LO];
                    lane_b_bytemask_r <= sec[`CPD_MB_HI:`CPD_MB_LO];
                end
                if (xop_act)
                begin
                    ext_bank_r <= sec[`CPD_XBANK_HI:`CPD_XBANK_LO];
                    ext_prech_r <= xop[`CPD_XOP_EXTENDED_PRECHARGE_CMD];
                    cal_drive_r <= xop[`CPD_XOP_CAL] ||
                        (xop[`CPD_XOP_SAM] && !xop[`CPD_XOP_CAL]);
                    cal_sample_r <= xop[`CPD_XOP_CAL] &&
                        xop[`CPD_XOP_SAM];
                end
            end
            // Relax wins over a same-cycle software attention request
            if ((take && prim_match && prim[`CPD_POP_RELAX]) ||
                (take && xop_act && xop[`CPD_XOP_RELAX]))
                attention_state_r <= 1'b0;
            else if (set_attention_state)
                attention_state_r <= 1'b1;
            else if (wr_go && wr_hit && (awaddr_r == `CPD_OFS_POWER) &&
                wstrb_r[0] && wdata_r[`CPD_PWR_STANDBY_STATE])
                attention_state_r <= 1'b0;
        end
    end

    // AXI4-Lite slave
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CPD_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `CPD_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= {ADDR_W{1'b0}};
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            own_device_identifier_r <= `CPD_DEVID_RST;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `CPD_RESP_OKAY : `CPD_RESP_SLVERR;
                if ((awaddr_r == `CPD_OFS_DEVID) && wstrb_r[0])
                    own_device_identifier_r <= wdata_r[4:0];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                s_axi_arvalid;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_hit ? `CPD_RESP_OKAY : `CPD_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== design/cpd_defines.vh ====
// Constants for the column packet decoder
`ifndef CPD_DEFINES_VH
`define CPD_DEFINES_VH

// Register byte offsets
`define CPD_OFS_DEVID 4'h0
`define CPD_OFS_POWER 4'h4
`define CPD_OFS_MASK 4'h8
`define CPD_OFS_COUNT 4'hc

// Reset values
`define CPD_DEVID_RST 5'h00
`define CPD_MASK_RST 8'hff

// Power register bits
`define CPD_PWR_ATTENTION_STATE 0
`define CPD_PWR_STANDBY_STATE 1

// AXI responses
`define CPD_RESP_OKAY 2'h0
`define CPD_RESP_SLVERR 2'h2

// Sampled pin vector layout
`define CPD_PIN_W 39
`define CPD_PIN_FRAME 38
`define CPD_PRIM_HI 37
`define CPD_PRIM_LO 17
`define CPD_SEC_HI 16
`define CPD_SEC_LO 0

// Primary packet fields, relative to the primary slice
`define CPD_PDEV_HI 20
`define CPD_PDEV_LO 16
`define CPD_PBANK_HI 15
`define CPD_PBANK_LO 11
`define CPD_PCOL_HI 10
`define CPD_PCOL_LO 4
`define CPD_POP_RELAX 3
`define CPD_POP_LOW_HI 2
`define CPD_POP_LOW_LO 0

// Primary opcode low bits
`define CPD_OP_NOP 3'h0
`define CPD_OP_WR 3'h1
`define CPD_OP_RSV0 3'h2
`define CPD_OP_RD 3'h3
`define CPD_OP_COLUMN_PRECHARGE_CMD 3'h4
`define CPD_OP_WRA 3'h5
`define CPD_OP_RSV1 3'h6
`define CPD_OP_RDA 3'h7

// Secondary packet fields, relative to the secondary slice
`define CPD_SEL_BIT 16
`define CPD_MB_HI 15
`define CPD_MB_LO 8
`define CPD_MA_HI 7
`define CPD_MA_LO 0
`define CPD_XDEV_HI 14
`define CPD_XDEV_LO 10
`define CPD_XBANK_HI 9
`define CPD_XBANK_LO 5
`define CPD_XOP_HI 4
`define CPD_XOP_LO 0
`define CPD_XOP_NOP 5'h00
`define CPD_XOP_EXTENDED_PRECHARGE_CMD 4
`define CPD_XOP_CAL 3
`define CPD_XOP_SAM 2
`define CPD_XOP_RELAX 1
`define CPD_XOP_RSV 0

`endif

// ==== bench/cpd_chk.sv ====
// Assertion checker for the column packet decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_chk (
    input wire aclk,
    input wire aresetn,
    input wire [20:0] primary_column_packet,
    input wire [16:0] secondary_packet,
    input wire attention_state_r,
    input wire retire_r,
    input wire write_r,
    input wire read_r,
    input wire col_prech_r,
    input wire auto_prech_r,
    input wire [4:0] bank_r,
    input wire [4:0] auto_bank_r,
    input wire ext_prech_r,
    input wire [4:0] ext_bank_r,
    input wire cal_drive_r,
    input wire cal_sample_r,
    input wire [7:0] lane_a_bytemask_r
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_rda_hit;
        read_r && $past(primary_column_packet[2]);
    endsequence
    sequence s_auto_ok;
        auto_prech_r && auto_bank_r == $past(bank_r);
    endsequence
    property p_rda;
        s_rda_hit |=> s_auto_ok;
    endproperty
    a_rda: assert property (p_rda) else $error("no auto precharge");
    property p_wr;
        write_r |-> retire_r && $past(primary_column_packet[1:0]) == 2'h1;
    endproperty
    a_wr: assert property (p_wr) else $error("write decode wrong");
    property p_rd;
        read_r |-> retire_r && $past(primary_column_packet[1:0]) == 2'h3;
    endproperty
    a_rd: assert property (p_rd) else $error("read decode wrong");
    property p_column_precharge_cmd;
        col_prech_r |-> retire_r && $past(primary_column_packet[2:0]) == 3'h4
            && bank_r == $past(primary_column_packet[15:11]);
    endproperty
    a_column_precharge_cmd: assert property (p_column_precharge_cmd) else $error("precharge wrong");
    property p_relax;
        write_r && $past(primary_column_packet[3])
            |-> ##[0:1] !attention_state_r;
    endproperty
    a_relax: assert property (p_relax) else $error("no standby");
    property p_standby_state;
        retire_r |-> $past(attention_state_r);
    endproperty
    a_standby_state: assert property (p_standby_state) else $error("standby take");
    property p_mask;
        $changed(lane_a_bytemask_r) |-> $past(secondary_packet[16])
            && lane_a_bytemask_r == $past(secondary_packet[7:0]);
    endproperty
    a_mask: assert property (p_mask) else $error("bad mask");
    property p_sam;
        cal_sample_r |-> cal_drive_r && !$past(secondary_packet[0])
            && $past(secondary_packet[3:2]) == 2'h3;
    endproperty
    a_sam: assert property (p_sam) else $error("sample wrong");
    property p_cal;
        cal_drive_r |-> !$past(secondary_packet[16])
            && !$past(secondary_packet[0])
            && $past(secondary_packet[3:2]) != 2'h0;
    endproperty
    a_cal: assert property (p_cal) else $error("bad calibrate");
    property p_ext;
        ext_prech_r |-> !$past(secondary_packet[16])
            && $past(secondary_packet[4])
            && !$past(secondary_packet[0])
            && ext_bank_r == $past(secondary_packet[9:5]);
    endproperty
    a_ext: assert property (p_ext) else $error("bad ext precharge");
endmodule
bind cpd_column_packet_decoder cpd_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .primary_column_packet(primary_column_packet),
    .secondary_packet(secondary_packet), .retire_r(retire_r),
    .attention_state_r(attention_state_r), .write_r(write_r), .read_r(read_r),
    .col_prech_r(col_prech_r), .auto_prech_r(auto_prech_r), .bank_r(bank_r),
    .auto_bank_r(auto_bank_r), .ext_prech_r(ext_prech_r),
    .ext_bank_r(ext_bank_r), .cal_drive_r(cal_drive_r),
    .cal_sample_r(cal_sample_r), .lane_a_bytemask_r(lane_a_bytemask_r));
`default_nettype wire

// ==== bench/cpd_ctrl_model.sv ====
// Controller model driving the column packet pins
`timescale 1ns/1ps
`default_nettype none
module cpd_ctrl_model (
    input wire aclk,
    input wire go,
    input wire frame,
    input wire [37:0] pkt,
    output logic col_frame_pin = 1'h0,
    output logic [20:0] primary_column_packet = 21'h0,
    output logic [16:0] secondary_packet = 17'h0,
    output logic done = 1'h0
);
    logic [3:0] cnt = 4'h0;
    always @(posedge aclk)
    begin
        done <= 1'h0;
        if (cnt == 4'h0 && go)
        begin
            {primary_column_packet, secondary_packet} <= pkt;
            col_frame_pin <= frame;
            cnt <= 4'h1;
        end
        else if (cnt == 4'h6)
        begin
            // Released lines show the inverse, frame drops between packets
            col_frame_pin <= 1'h0;
            {primary_column_packet, secondary_packet} <= ~pkt;
            cnt <= cnt + 4'h1;
        end
        else if (cnt == 4'hc)
        begin
            done <= 1'h1;
            cnt <= 4'h0;
        end
        else if (cnt != 4'h0)
            cnt <= cnt + 4'h1;
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench for the column packet decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, go = 1'h0, frame = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [37:0] pkt = 38'h0;
    logic [7:0] seen = 8'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire col_frame_pin, done, attention_state_r, retire_r, write_r, read_r;
    wire col_prech_r, auto_prech_r, ext_prech_r, cal_drive_r, cal_sample_r;
    wire [20:0] primary_column_packet;
    wire [16:0] secondary_packet;
    wire [4:0] bank_r, auto_bank_r, ext_bank_r;
    wire [6:0] column_r;
    wire [7:0] lane_a_bytemask_r, lane_b_bytemask_r;
    int err_total = 0, compares = 0;
    logic [7:0] pe [8] = '{8'h01, 8'h03, 8'h01, 8'h05, 8'h09, 8'h03,
        8'h11, 8'h15};
    logic [4:0] xo [6] = '{5'h10, 5'h08, 5'h0c, 5'h04, 5'h01, 5'h11};
    logic [7:0] xe [6] = '{8'h21, 8'h41, 8'hc1, 8'h41, 8'h01, 8'h01};
    always #2.5 aclk = ~aclk;
    cpd_column_packet_decoder dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .col_frame_pin, .primary_column_packet, .secondary_packet,
        .attention_state_r, .retire_r, .write_r, .read_r, .col_prech_r,
        .auto_prech_r, .bank_r, .column_r, .auto_bank_r, .ext_prech_r,
        .ext_bank_r, .cal_drive_r, .cal_sample_r, .lane_a_bytemask_r,
        .lane_b_bytemask_r);
    cpd_ctrl_model u_ctl (.aclk, .go, .frame, .pkt, .col_frame_pin,
        .primary_column_packet, .secondary_packet, .done);
    always @(posedge aclk)
        seen <= go ? 8'h0 : seen | {cal_sample_r, cal_drive_r, ext_prech_r,
            auto_prech_r, col_prech_r, read_r, write_r, retire_r};
    task stop_test;
    begin
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    begin
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    end
    endtask
    task axw(input logic [3:0] a, input logic [31:0] v);
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, (a == 4'h0 || a == 4'h4) ? 2'h0 : 2'h2, "bresp");
        @(posedge aclk);
    end
    endtask
    task axr(input logic [3:0] a, input logic [1:0] er);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp, er, "rresp");
        @(posedge aclk);
    end
    endtask
    task pk(input logic f, input logic [4:0] dv, input logic [3:0] op,
        input logic [16:0] sec, input logic [7:0] e);
    begin
        pkt <= {dv, 1'h0, op, 7'h55, op, sec};
        frame <= f;
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
        do @(posedge aclk); while (done !== 1'h1);
        chk(seen, e, "pulses");
    end
    endtask
    initial
    begin
        repeat (5000) @(posedge aclk);
        err_total++;
        stop_test;
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        axr(4'h8, 2'h0);
        chk(d, 32'h0000ffff, "masks");
        axr(4'h2, 2'h2);
        chk(d, 32'h0, "unmapped");
        axw(4'h0, 32'h3);
        axr(4'h0, 2'h0);
        chk(d, 32'h3, "device id");
        pk(1'h1, 5'h4, 4'h1, 17'h00c00, 8'h01);
        pk(1'h0, 5'h3, 4'h1, 17'h00c00, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            pk(1'h1, 5'h3, i[3:0], 17'h00c00, pe[i]);
            chk(bank_r, i, "bank");
            if (i == 6)
                chk(auto_bank_r, 5'h5, "wra bank");
        end
        chk(auto_bank_r, 5'h7, "rda bank");
        chk(column_r, 7'h55, "column");
        for (int i = 0; i < 6; i++)
            pk(1'h1, 5'h3, 4'h0, {12'h067, xo[i]}, xe[i]);
        chk(ext_bank_r, 5'h7, "ext bank");
        pk(1'h1, 5'h3, 4'h0, 17'h01090, 8'h01);
        pk(1'h1, 5'h3, 4'h0, 17'h00c02, 8'h01);
        chk(attention_state_r, 1'h0, "attention");
        axw(4'h4, 32'h1);
        pk(1'h1, 5'h3, 4'h0, 17'h00cf2, 8'h21);
        chk(attention_state_r, 1'h0, "attention");
        axw(4'h4, 32'h1);
        pk(1'h1, 5'h3, 4'h0, 17'h15aa5, 8'h01);
        axr(4'h8, 2'h0);
        chk(d, 32'h00005aa5, "masks");
        axw(4'h8, 32'h0);
        axr(4'h8, 2'h0);
        chk(d, 32'h00005aa5, "masks ro");
        pk(1'h1, 5'h3, 4'h9, 17'h00c00, 8'h03);
        chk(attention_state_r, 1'h0, "attention");
        // Frozen decoder must not see this packet at all
        ce <= 1'h0;
        pk(1'h1, 5'h3, 4'h1, 17'h00c00, 8'h00);
        ce <= 1'h1;
        pk(1'h1, 5'h3, 4'h1, 17'h00c00, 8'h00);
        axr(4'hc, 2'h0);
        chk(d[31:16], 16'h1, "refused");
        chk(d[15:0], 16'h14, "taken");
        axw(4'h4, 32'h1);
        axr(4'h4, 2'h0);
        chk(d[0], 1'h1, "power");
        axw(4'h4, 32'h2);
        axr(4'h4, 2'h0);
        chk(d[0], 1'h0, "power");
        axw(4'h4, 32'h3);
        axr(4'h4, 2'h0);
        chk(d[0], 1'h1, "power");
        stop_test;
    end
endmodule
`default_nettype wire
